//--- sim/spi_far_slave.sv
/*
  Slave model on the serial side: clock mode 0, MSB first, byte frames.
  Assumes the block under test is master and drives sck and mosi.
*/
`timescale 1ns/10ps
module spi_far_slave (
  // Serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Frame data
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [2:0] n_rise = 3'h0;
  logic [2:0] n_fall = 3'h0;
  logic [7:0] sh     = 8'h00;
  // Sample on rise, keep each whole byte
  always @(posedge sck) begin
    sh     <= {sh[6:0], mosi};
    n_rise <= n_rise + 3'h1;
    if (n_rise == 3'h7) rx_byte <= {sh[6:0], mosi};
  end
  // Next bit on fall
  always @(negedge sck) n_fall <= n_fall + 3'h1;
  assign miso = tx_byte[3'h7 - n_fall];
endmodule

//--- sim/tb_spi_status_data_regs.sv
/*
  Testbench of the serial status and data register block.
  Assumes the far slave model; an APB master task drives the bus.
*/
`timescale 1ns/10ps
module tb_spi_status_data_regs;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        ss_n_in = 1'b1;
  logic [7:0]  ptx     = 8'h00;
  logic        pready, pslverr, irq, e, sck_out, sck_oe, mosi_out, mosi_oe, miso_w;
  logic [31:0] prdata, r;
  logic [7:0]  prx, d1, d2;
  wire logic   sck_w  = sck_oe ? sck_out : 1'b0;
  wire logic   mosi_w = mosi_oe ? mosi_out : 1'b0;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          exp_q[$];

  // Clock
  always #20 pclk = ~pclk;

  spi_status_data_regs #(.SCK_HALF(4)) u_spi_status_data_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(), .miso_oe(), .ss_n_in(ss_n_in), .irq(irq));

  spi_far_slave u_spi_far_slave (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .tx_byte(ptx), .rx_byte(prx));

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll status until receive-full
  task automatic wait_full();
    int n;
    for (n = 0; n < 60; n++) begin
      apb(1'b0, 8'h0C, 8'h00);
      if (r[7] === 1'b1) break;
    end
    if (n == 60) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // Status read then low-byte write, queues one word
  task automatic push_word(input logic [7:0] v);
    apb(1'b0, 8'h0C, 8'h00);
    apb(1'b1, 8'h14, v);
  endtask

  // Main sequence
  initial begin
    void'($urandom(14));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    ptx <= 8'($urandom);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    apb(1'b0, 8'h10, 8'h00); chk(r, 32'h00);
    apb(1'b0, 8'h14, 8'h00); chk(r, 32'h00);
    apb(1'b1, 8'h0C, 8'hFF); apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    apb(1'b0, 8'h18, 8'h00); chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h00, 8'h10);
    apb(1'b0, 8'h0C, 8'h00); apb(1'b1, 8'h14, d1); exp_q.push_back(ptx);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    apb(1'b1, 8'h14, d2); exp_q.push_back(ptx);
    apb(1'b1, 8'h14, ~d2); apb(1'b1, 8'h10, 8'h5A);
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h00);
    wait_full(); chk({24'h0, prx}, {24'h0, d1});
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'hA0);
    apb(1'b0, 8'h10, 8'h00); apb(1'b0, 8'h0C, 8'h00); chk(r, 32'hA0);
    apb(1'b0, 8'h14, 8'h00); chk(r, 32'(exp_q.pop_front()));
    wait_full(); chk({24'h0, prx}, {24'h0, d2});
    apb(1'b0, 8'h14, 8'h00); chk(r, 32'(exp_q.pop_front()));
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    push_word(d1); push_word(d2); repeat (150) @(posedge pclk);
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'hA0);
    push_word(d1); apb(1'b0, 8'h14, 8'h00); chk(r, {24'h0, ptx});
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    wait_full(); chk({24'h0, prx}, {24'h0, d1});
    exp_q.push_back(ptx); ptx <= ~ptx; push_word(d2); exp_q.push_back(ptx);
    repeat (80) @(posedge pclk);
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'hA0);
    apb(1'b0, 8'h14, 8'h00); chk(r, 32'(exp_q.pop_front()));
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'hA0);
    apb(1'b0, 8'h14, 8'h00); chk(r, 32'(exp_q.pop_front()));
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    chk({24'h0, prx}, {24'h0, d2});
    apb(1'b1, 8'h04, 8'h10); apb(1'b1, 8'h00, 8'h90);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge pclk);
    ss_n_in <= 1'b1;
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h30);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h00, 8'h80); apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h04, 8'h40); apb(1'b1, 8'h00, 8'h10); apb(1'b1, 8'h10, d1); push_word(d2);
    wait_full(); chk({24'h0, prx}, {24'h0, d2});
    apb(1'b0, 8'h10, 8'h00); chk(r, {24'h0, ptx});
    apb(1'b0, 8'h0C, 8'h00); apb(1'b0, 8'h14, 8'h00); chk(r, {24'h0, ptx});
    apb(1'b0, 8'h0C, 8'h00); chk(r, 32'h20);
    report_and_stop();
  end
endmodule

//--- src/pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes each bit is an independent level from outside the pclk domain.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned         WIDTH     = 1,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pins and synchronised copies
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_s;

  sync_s q;
  sync_s d;

  // Second stage reads only the first
  always_comb begin
    d      = q;
    d.meta = din;
    d.sync = q.meta;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {RESET_VAL, RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign dout = q.sync;

endmodule

//--- src/shift_engine.sv
/*
  Serial shift engine, clock phase 0 and polarity 0, most significant bit first.
  Assumes synchronised pin levels; in master mode it makes the serial clock by
  dividing pclk, in slave mode it finds edges of the sampled serial clock.
*/
`timescale 1ns/10ps
module shift_engine #(
  parameter int unsigned HALF_CYCLES = spi_regs_pkg::SCK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire logic        master,
  input  wire logic        wide,
  input  wire logic        abort,
  // Transmit word
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_word,
  // Synchronised pins
  input  wire logic        sck_s,
  input  wire logic        din_s,
  input  wire logic        ss_n_s,
  // Results
  output logic             sck_q,
  output logic             dout_q,
  output logic             start_q,
  output logic             done_q,
  output logic      [15:0] rx_q
);

  typedef struct packed {
    spi_regs_pkg::link_state_e st;
    logic [15:0]               sh;
    logic [4:0]                cnt;
    logic [7:0]                div;
    logic                      sck;
    logic                      sck_prev;
    logic                      ss_prev;
    logic                      dout;
    logic                      start;
    logic                      done;
    logic [15:0]               rx;
  } eng_s;

  eng_s q;
  eng_s d;
  logic [4:0] bits;

  // Bit count follows the width selection
  assign bits = wide ? spi_regs_pkg::WORD_BITS : spi_regs_pkg::BYTE_BITS;

  // Next state of the engine
  always_comb begin
    d          = q;
    d.start    = 1'b0;
    d.done     = 1'b0;
    d.sck_prev = sck_s;
    d.ss_prev  = ss_n_s;
    case (q.st)
      spi_regs_pkg::LINK_IDLE: begin
        d.sck = 1'b0;
        d.div = 8'h00;
        d.cnt = 5'h00;
        if ((master && tx_valid) || (!master && q.ss_prev && !ss_n_s)) begin
          d.st    = spi_regs_pkg::LINK_SHIFT;
          d.start = 1'b1;
          d.sh    = tx_valid ? tx_word : 16'h0000;
          d.dout  = wide ? d.sh[15] : d.sh[7];
        end
      end
      spi_regs_pkg::LINK_SHIFT: begin
        if (abort || (!master && ss_n_s)) begin
          d.st  = spi_regs_pkg::LINK_IDLE;
          d.sck = 1'b0;
        end else if (master) begin
          if (q.div == 8'(HALF_CYCLES - 1)) begin
            d.div = 8'h00;
            if (!q.sck) begin
              d.sck = 1'b1;
              d.sh  = {q.sh[14:0], din_s};
              d.cnt = 5'(q.cnt + 5'h01);
            end else begin
              d.sck = 1'b0;
              if (q.cnt == bits) begin
                d.st = spi_regs_pkg::LINK_DONE;
              end else begin
                d.dout = wide ? q.sh[15] : q.sh[7];
              end
            end
          end else begin
            d.div = 8'(q.div + 8'h01);
          end
        end else begin
          if (sck_s && !q.sck_prev) begin
            d.sh  = {q.sh[14:0], din_s};
            d.cnt = 5'(q.cnt + 5'h01);
            if (5'(q.cnt + 5'h01) == bits) begin
              d.st = spi_regs_pkg::LINK_DONE;
            end
          end
          if (!sck_s && q.sck_prev) begin
            d.dout = wide ? q.sh[15] : q.sh[7];
          end
        end
      end
      spi_regs_pkg::LINK_DONE: begin
        d.done = 1'b1;
        d.rx   = wide ? q.sh : {8'h00, q.sh[7:0]};
        d.st   = spi_regs_pkg::LINK_IDLE;
      end
      default: begin
        d.st = spi_regs_pkg::LINK_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.st       <= spi_regs_pkg::LINK_IDLE;
      q.ss_prev  <= 1'b1;
      q.rx       <= spi_regs_pkg::WORD_RESET;
    end else begin
      q <= d;
    end
  end

  assign sck_q   = q.sck;
  assign dout_q  = q.dout;
  assign start_q = q.start;
  assign done_q  = q.done;
  assign rx_q    = q.rx;

endmodule

//--- src/spi_regs_pkg.sv
/*
  Shared constants of the serial status and data register block: register
  indices, field positions, reset values, engine states and link timing.
  Assumes a 32-bit APB bus with byte addresses equal to four times the index.
*/
package spi_regs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W  = ADDR_W - 2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] CTRL_ONE_IDX = 6'h00;
  localparam logic [IDX_W-1:0] CTRL_TWO_IDX = 6'h01;
  localparam logic [IDX_W-1:0] STATUS_IDX   = 6'h03;
  localparam logic [IDX_W-1:0] WORD_HI_IDX  = 6'h04;
  localparam logic [IDX_W-1:0] WORD_LO_IDX  = 6'h05;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned RX_FULL_BIT   = 7;
  localparam int unsigned TX_EMPTY_BIT  = 5;
  localparam int unsigned FAULT_BIT     = 4;
  localparam int unsigned MASTER_BIT    = 4;
  localparam int unsigned IRQ_EN_BIT    = 7;
  localparam int unsigned FAULT_EN_BIT  = 4;
  localparam int unsigned WIDTH_SEL_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [4:0]  BYTE_BITS      = 5'h08;
  localparam logic [4:0]  WORD_BITS      = 5'h10;

  // ----------------------------------------------------------------
  // Link timing: pclk cycles per half period of the master clock
  // ----------------------------------------------------------------
  localparam int unsigned SCK_HALF_CYCLES = 4;

  // ----------------------------------------------------------------
  // Shift engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LINK_IDLE  = 3'b001,
    LINK_SHIFT = 3'b010,
    LINK_DONE  = 3'b100
  } link_state_e;

endpackage

//--- src/spi_status_data_regs.sv
/*
  Status flags and double-buffered data register of a serial peripheral,
  reached over APB, with the shift engine and pin synchroniser below it.
  Assumes serial pins are asynchronous to pclk; the testbench resolves the
  sck and mosi wires from their output enables.
*/
`timescale 1ns/10ps
module spi_status_data_regs #(
  parameter int unsigned SCK_HALF = spi_regs_pkg::SCK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [spi_regs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                     pwdata,
  output logic                                 pready,
  output logic      [31:0]                     prdata,
  output logic                                 pslverr,
  // Serial pins
  input  wire logic                            sck_in,
  output logic                                 sck_out,
  output logic                                 sck_oe,
  input  wire logic                            mosi_in,
  output logic                                 mosi_out,
  output logic                                 mosi_oe,
  input  wire logic                            miso_in,
  output logic                                 miso_out,
  output logic                                 miso_oe,
  input  wire logic                            ss_n_in,
  // Interrupt request
  output logic                                 irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  serial_control_one;
    logic [7:0]  serial_control_two;
    logic        receive_full_flag;
    logic        rf_armed;
    logic [15:0] rx_data;
    logic        held_valid;
    logic [15:0] held_word;
    logic        transmit_empty_flag;
    logic        te_armed;
    logic [15:0] tx_word;
    logic        mode_fault_flag;
    logic        mf_armed;
    logic        irq;
    logic        sck_oe;
    logic        mosi_oe;
    logic        miso_oe;
  } regs_s;

  regs_s q;
  regs_s d;

  logic [3:0]                    pins_s;
  logic                          sck_s;
  logic                          mosi_s;
  logic                          miso_s;
  logic                          ss_n_s;
  logic                          eng_sck;
  logic                          eng_dout;
  logic                          eng_start;
  logic                          eng_done;
  logic [15:0]                   eng_rx;
  logic [spi_regs_pkg::IDX_W-1:0] idx;
  logic                          hit;
  logic                          prep;
  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic                          master;
  logic                          fault_set;
  logic                          service;
  logic [7:0]                    status_byte;

  // ----------------------------------------------------------------
  // Pin synchroniser and shift engine
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h1)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({sck_in, mosi_in, miso_in, ss_n_in}),
    .dout    (pins_s)
  );

  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_n_s = pins_s[0];

  shift_engine #(
    .HALF_CYCLES (SCK_HALF)
  ) u_shift_engine (
    .pclk     (pclk),
    .presetn  (presetn),
    .master   (master),
    .wide     (q.serial_control_two[spi_regs_pkg::WIDTH_SEL_BIT]),
    .abort    (fault_set),
    .tx_valid (!q.transmit_empty_flag),
    .tx_word  (q.tx_word),
    .sck_s    (sck_s),
    .din_s    (master ? miso_s : mosi_s),
    .ss_n_s   (ss_n_s),
    .sck_q    (eng_sck),
    .dout_q   (eng_dout),
    .start_q  (eng_start),
    .done_q   (eng_done),
    .rx_q     (eng_rx)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Phase qualifiers; one wait state before pready
  assign idx     = paddr[spi_regs_pkg::ADDR_W-1:2];
  assign hit     = (paddr[1:0] == 2'h0) &&
                   (idx == spi_regs_pkg::CTRL_ONE_IDX || idx == spi_regs_pkg::CTRL_TWO_IDX ||
                    idx == spi_regs_pkg::STATUS_IDX || idx == spi_regs_pkg::WORD_HI_IDX ||
                    idx == spi_regs_pkg::WORD_LO_IDX);
  assign prep    = psel && penable && !q.pready;
  assign acc     = psel && penable && q.pready;
  assign wr      = acc && pwrite && hit;
  assign rd      = acc && !pwrite && hit;
  assign master  = q.serial_control_one[spi_regs_pkg::MASTER_BIT];
  assign service = rd && (idx == spi_regs_pkg::WORD_LO_IDX) && q.rf_armed;

  // Mode fault detection
  assign fault_set = master && q.serial_control_two[spi_regs_pkg::FAULT_EN_BIT] && !ss_n_s;

  // Status byte as seen by software, reserved bits zero
  always_comb begin
    status_byte                             = 8'h00;
    status_byte[spi_regs_pkg::RX_FULL_BIT]  = q.receive_full_flag;
    status_byte[spi_regs_pkg::TX_EMPTY_BIT] = q.transmit_empty_flag;
    status_byte[spi_regs_pkg::FAULT_BIT]    = q.mode_fault_flag;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // Read data and error prepared one cycle ahead of pready
    if (prep) begin
      d.pready  = 1'b1;
      d.pslverr = !hit;
      d.prdata  = 32'h0000_0000;
      if (hit) begin
        case (idx)
          spi_regs_pkg::CTRL_ONE_IDX: d.prdata[7:0] = q.serial_control_one;
          spi_regs_pkg::CTRL_TWO_IDX: d.prdata[7:0] = q.serial_control_two;
          spi_regs_pkg::STATUS_IDX:   d.prdata[7:0] = status_byte;
          spi_regs_pkg::WORD_HI_IDX:  d.prdata[7:0] = q.rx_data[15:8];
          spi_regs_pkg::WORD_LO_IDX:  d.prdata[7:0] = q.rx_data[7:0];
          default:                    d.prdata[7:0] = 8'h00;
        endcase
      end
    end

    // Control writes; control one write ends an armed fault
    if (wr && idx == spi_regs_pkg::CTRL_ONE_IDX) begin
      d.serial_control_one = pwdata[7:0];
      if (q.mf_armed) begin
        d.mode_fault_flag = 1'b0;
        d.mf_armed        = 1'b0;
      end
    end
    if (wr && idx == spi_regs_pkg::CTRL_TWO_IDX) begin
      d.serial_control_two = pwdata[7:0];
    end

    // Fault sets after any clear and drops master mode
    if (fault_set) begin
      d.mode_fault_flag                             = 1'b1;
      d.serial_control_one[spi_regs_pkg::MASTER_BIT] = 1'b0;
    end

    // Status read arms each clearing sequence from the value returned
    if (rd && idx == spi_regs_pkg::STATUS_IDX) begin
      d.rf_armed = q.prdata[spi_regs_pkg::RX_FULL_BIT];
      d.te_armed = q.prdata[spi_regs_pkg::TX_EMPTY_BIT];
      d.mf_armed = q.prdata[spi_regs_pkg::FAULT_BIT];
    end

    // Receive service: held word moves up or the flag clears
    if (service) begin
      d.rf_armed = 1'b0;
      if (q.held_valid) begin
        d.rx_data    = q.held_word;
        d.held_valid = 1'b0;
      end else begin
        d.receive_full_flag = 1'b0;
      end
    end

    // Held word dies when another transfer starts unserviced
    if (eng_start && q.held_valid && !service) begin
      d.held_valid = 1'b0;
    end

    // Completed word: into data register if free, else held
    if (eng_done) begin
      if (!q.receive_full_flag || (service && !q.held_valid)) begin
        d.rx_data           = eng_rx;
        d.receive_full_flag = 1'b1;
      end else begin
        d.held_word  = eng_rx;
        d.held_valid = 1'b1;
      end
    end

    // Transmit loads accepted only while empty
    if (wr && q.transmit_empty_flag && idx == spi_regs_pkg::WORD_HI_IDX) begin
      d.tx_word[15:8] = pwdata[7:0];
    end
    if (wr && q.transmit_empty_flag && idx == spi_regs_pkg::WORD_LO_IDX) begin
      d.tx_word[7:0] = pwdata[7:0];
      if (q.te_armed) begin
        d.transmit_empty_flag = 1'b0;
        d.te_armed            = 1'b0;
      end
    end

    // Engine took the queued word
    if (eng_start && !q.transmit_empty_flag) begin
      d.transmit_empty_flag = 1'b1;
    end

    // Pin enables and interrupt, registered
    d.sck_oe  = d.serial_control_one[spi_regs_pkg::MASTER_BIT];
    d.mosi_oe = d.serial_control_one[spi_regs_pkg::MASTER_BIT];
    d.miso_oe = !d.serial_control_one[spi_regs_pkg::MASTER_BIT] && !ss_n_s;
    d.irq     = d.mode_fault_flag && d.serial_control_one[spi_regs_pkg::IRQ_EN_BIT];
  end

  // State register; transmit register starts empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                     <= '0;
      q.serial_control_one  <= spi_regs_pkg::CTRL_ONE_RESET;
      q.serial_control_two  <= spi_regs_pkg::CTRL_TWO_RESET;
      q.rx_data             <= spi_regs_pkg::WORD_RESET;
      q.tx_word             <= spi_regs_pkg::WORD_RESET;
      q.transmit_empty_flag <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready   = q.pready;
  assign prdata   = q.prdata;
  assign pslverr  = q.pslverr;
  assign sck_out  = eng_sck;
  assign sck_oe   = q.sck_oe;
  assign mosi_out = eng_dout;
  assign mosi_oe  = q.mosi_oe;
  assign miso_out = eng_dout;
  assign miso_oe  = q.miso_oe;
  assign irq      = q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_wr;
    wr && idx == spi_regs_pkg::STATUS_IDX && !eng_done && !eng_start && !fault_set;
  endsequence

  sequence s_low_service;
    service && !eng_done;
  endsequence

  a_status_write_ignored: assert property (s_status_wr |=> $stable(status_byte))
    else $error("status write changed a flag");
  a_rx_full_on_done: assert property (eng_done && !q.receive_full_flag |=>
    q.receive_full_flag && q.rx_data == $past(eng_rx))
    else $error("received word not moved into data register");
  a_te_read_value: assert property (prep && idx == spi_regs_pkg::STATUS_IDX && hit |=>
    prdata[spi_regs_pkg::TX_EMPTY_BIT] == $past(q.transmit_empty_flag))
    else $error("status read shows wrong transmit-empty value");
  a_fault_sets_flag: assert property (fault_set |=> q.mode_fault_flag && !master ##1 irq ==
    q.serial_control_one[spi_regs_pkg::IRQ_EN_BIT])
    else $error("mode fault not flagged");
  a_fault_clear_seq: assert property (q.mf_armed && wr && idx == spi_regs_pkg::CTRL_ONE_IDX &&
    !fault_set |=> !q.mode_fault_flag)
    else $error("mode fault not cleared by armed write");
  a_high_read_keeps: assert property (rd && idx == spi_regs_pkg::WORD_HI_IDX && !eng_done |=>
    $stable(q.receive_full_flag))
    else $error("high byte read changed receive-full");
  a_low_read_clears: assert property (s_low_service and !q.held_valid |=> !q.receive_full_flag)
    else $error("armed low read did not clear receive-full");
  a_te_clear_seq: assert property (q.te_armed && wr && q.transmit_empty_flag &&
    idx == spi_regs_pkg::WORD_LO_IDX |=> !q.transmit_empty_flag)
    else $error("armed low write did not clear transmit-empty");
  a_full_write_ignored: assert property (wr && !q.transmit_empty_flag |=> $stable(q.tx_word))
    else $error("write while full altered transmit word");
  a_master_starts: assert property (master && !q.transmit_empty_flag && !fault_set && !eng_start
    ##1 master && !fault_set |-> ##[0:3] eng_start or ##[1:300] eng_done)
    else $error("queued master word not started");
  a_held_moves_up: assert property (s_low_service and q.held_valid |=>
    q.receive_full_flag && q.rx_data == $past(q.held_word) && !q.held_valid)
    else $error("held word not moved on service");
  a_held_dropped: assert property (eng_start && q.held_valid && !service && !eng_done |=>
    !q.held_valid)
    else $error("held word survived another start");
  a_te_set_on_take: assert property (eng_start && !q.transmit_empty_flag |=>
    q.transmit_empty_flag)
    else $error("transmit-empty not set when word taken");

endmodule
